/* logic/tbl_locator.sv */
// four-drive tape block locator with ahb-lite register slave
`timescale 1ns/100ps
`include "tbl_params.svh"
module tbl_locator
    import tbl_pkg::*;
#(
    parameter int ERR_WIN_CYC = `TBL_ERR_WIN_US * `TBL_CLK_MHZ
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // ahb-lite slave
    input  wire logic         hsel_in,
    input  wire logic [31:0]  haddr_in,
    input  wire logic [1:0]   htrans_in,
    input  wire logic         hwrite_in,
    input  wire logic [2:0]   hsize_in,
    input  wire logic [31:0]  hwdata_in,
    input  wire logic         hready_in,
    output logic      [31:0]  hrdata_out,
    output logic              hreadyout_out,
    output logic              hresp_out,
    // tape unit pins, asynchronous
    input  wire tbl_pins_t    pins_in,
    // tape unit drive outputs
    output logic      [3:0]   motor_fwd_out,
    output logic      [3:0]   motor_rev_out,
    output logic      [3:0]   brake_out,
    output logic      [3:0]   erase_out,
    output logic      [3:0]   head_write_out,
    output logic      [1:0]   write_pair_out,
    // shared tape sequencer
    input  wire logic         seq_write_flag_in,
    output tbl_seq_t          seq_out,
    // main memory word fetch
    output logic      [9:0]   mem_addr_out,
    input  wire logic [35:0]  mem_data_in,
    // interrupt
    output logic              irq_out
);

    localparam logic [`TBL_WIN_W-1:0] WIN_LOAD =
        ERR_WIN_CYC[`TBL_WIN_W-1:0];

    // refuse a window the counter cannot hold
    if (ERR_WIN_CYC < 1 || ERR_WIN_CYC >= (1 << `TBL_WIN_W)) begin : g_chk
        $error("ERR_WIN_CYC out of range");
    end

    tbl_state_t r;
    tbl_state_t nx;
    logic [3:0] lpe;
    logic [3:0] wpe;
    logic [3:0] bpe;
    logic [3:0] stp;
    logic       wld;
    logic [3:0] busy_v;
    logic [3:0] err_v;
    logic [3:0] route_v;
    logic       addr_ph;
    logic [1:0] cu;

    // status vectors for the read mux
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            busy_v[k]  = r.drv[k].st != tbl_idle;
            err_v[k]   = r.drv[k].err;
            route_v[k] = r.drv[k].pulse_route_flag;
        end
    end

    assign addr_ph = hsel_in & hready_in & htrans_in[1];
    assign cu      = hwdata_in[`TBL_CMD_UNIT];

    // counter snapshot of one drive
    function automatic logic [31:0] cnt_word(input tbl_drv_t d);
        cnt_word = {3'h0, d.line_counter, 3'h0, d.word_counter,
                    4'h0, d.block_counter};
    endfunction

    // register read mux; unmapped offsets read zero
    function automatic logic [31:0] rd_word(input logic [7:0] off);
        logic [31:0] v;
        v = '0;
        case (off)
            `TBL_REG_CMD:    v = {28'h0, r.op, r.unit};
            `TBL_REG_VADDR:  v = {22'h0, r.vaddr};
            `TBL_REG_STATUS: v = {20'h0, err_v, route_v, busy_v};
            `TBL_REG_ISTAT:  v = {24'h0, r.stat};
            `TBL_REG_IMASK:  v = {24'h0, r.mask};
            `TBL_REG_CNT0:   v = cnt_word(r.drv[0]);
            `TBL_REG_CNT1:   v = cnt_word(r.drv[1]);
            `TBL_REG_CNT2:   v = cnt_word(r.drv[2]);
            `TBL_REG_CNT3:   v = cnt_word(r.drv[3]);
            default:         v = '0;
        endcase
        return v;
    endfunction

    // all next-state logic
    always_comb begin
        nx  = r;
        lpe = '0;
        wpe = '0;
        bpe = '0;
        stp = '0;
        wld = 1'b0;

        // two-stage synchroniser, edge found behind the second stage
        nx.s1   = pins_in;
        nx.s2   = r.s1;
        nx.lp_d = r.s2.line_pulse;
        lpe     = r.s2.line_pulse & ~r.lp_d;

        // bus: zero wait states, write lands in the data phase
        nx.hready = 1'b1;
        nx.hresp  = 1'b0;
        nx.wpend  = addr_ph & hwrite_in;
        nx.woff   = haddr_in[7:0];
        if (addr_ph && !hwrite_in) begin
            nx.hrdata = rd_word(haddr_in[7:0]);
        end
        nx.seq = '0;

        if (r.wpend) begin
            case (r.woff)
                `TBL_REG_VADDR: nx.vaddr = hwdata_in[`TBL_VADDR_F];
                `TBL_REG_IMASK: nx.mask  = hwdata_in[`TBL_IRQ_F];
                `TBL_REG_ISTAT: nx.stat  = r.stat & ~hwdata_in[`TBL_IRQ_F];
                `TBL_REG_CLEAR: begin
                    // manual clear after an error stop
                    for (int k = 0; k < 4; k++) begin
                        if (hwdata_in[k]) begin
                            nx.drv[k].err           = 1'b0;
                            nx.drv[k].line_counter  = '0;
                            nx.drv[k].word_counter  = '0;
                            nx.drv[k].block_counter = '0;
                            nx.drv[k].win           = '0;
                        end
                    end
                end
                `TBL_REG_CMD: begin
                    // start ignored while the drive is busy or in error
                    if (r.drv[cu].st == tbl_idle && !r.drv[cu].err) begin
                        nx.unit = cu;
                        nx.op   = tbl_op_t'(hwdata_in[`TBL_CMD_OP]);
                        nx.drv[cu].st = tbl_load;
                        nx.drv[cu].block_counter =
                            {1'b0, hwdata_in[`TBL_CMD_CNT]};
                        nx.drv[cu].line_counter = '0;
                        nx.drv[cu].word_counter = '0;
                        nx.drv[cu].back =
                            hwdata_in[`TBL_CMD_OP] == tbl_op_back;
                        // read and write route pulses, positioning not
                        nx.drv[cu].pulse_route_flag =
                            hwdata_in[3];
                        if (hwdata_in[`TBL_CMD_OP] == tbl_op_write) begin
                            nx.fetch    = r.vaddr;
                            nx.wld_pend = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end

        // per-drive locating logic, identical for each unit
        for (int j = 0; j < 4; j++) begin
            if (lpe[j]) begin
                // line pulse while the window is open is a fault
                if (r.drv[j].win != '0) begin
                    nx.drv[j].err     = 1'b1;
                    nx.drv[j].fwd_cmd = 1'b0;
                    nx.drv[j].rev_cmd = 1'b0;
                    nx.drv[j].st      = tbl_idle;
                    nx.drv[j].pulse_route_flag = 1'b0;
                end
                if (r.drv[j].line_counter == `TBL_LINE_LAST) begin
                    nx.drv[j].line_counter = '0;
                    wpe[j] = 1'b1;
                    if (r.drv[j].word_counter == `TBL_WORD_LAST) begin
                        nx.drv[j].word_counter = '0;
                        bpe[j] = 1'b1;
                    end else begin
                        nx.drv[j].word_counter =
                            r.drv[j].word_counter + 5'h01;
                    end
                end else begin
                    nx.drv[j].line_counter =
                        r.drv[j].line_counter + 5'h01;
                end
            end

            if (bpe[j]) begin
                nx.drv[j].win = WIN_LOAD;
                nx.drv[j].block_counter =
                    r.drv[j].block_counter - `TBL_BLK_ONE;
                stp[j] = r.drv[j].block_counter == `TBL_BLK_ZERO;
            end else if (r.drv[j].win != '0) begin
                nx.drv[j].win = r.drv[j].win - `TBL_WIN_ONE;
            end

            unique case (r.drv[j].st)
                tbl_idle: ;
                tbl_load: nx.drv[j].st = tbl_decr;
                tbl_decr: begin
                    // one decrement before motion: zero wraps and stops
                    nx.drv[j].block_counter =
                        r.drv[j].block_counter - `TBL_BLK_ONE;
                    stp[j] = r.drv[j].block_counter == `TBL_BLK_ZERO;
                    nx.drv[j].st      = tbl_run;
                    nx.drv[j].fwd_cmd = ~r.drv[j].back;
                    nx.drv[j].rev_cmd = r.drv[j].back;
                end
                tbl_run: ;
            endcase

            if (stp[j]) begin
                nx.drv[j].fwd_cmd = 1'b0;
                nx.drv[j].rev_cmd = 1'b0;
                nx.drv[j].st      = tbl_idle;
                nx.drv[j].pulse_route_flag = 1'b0;
            end

            // forward pulses only while routed
            if (r.drv[j].pulse_route_flag) begin
                nx.seq.line_pulse = nx.seq.line_pulse | lpe[j];
                nx.seq.word_pulse = nx.seq.word_pulse | wpe[j];
                nx.seq.stop       = nx.seq.stop | stp[j];
            end

            nx.drv[j].erase =
                r.drv[j].pulse_route_flag & seq_write_flag_in;
            nx.drv[j].head_we = r.drv[j].pulse_route_flag &
                seq_write_flag_in & lpe[j];

            // selector: automatic uses the gated commands, else manual
            if (r.s2.auto_sel[j]) begin
                nx.drv[j].mfwd = r.drv[j].fwd_cmd &
                    ~r.drv[j].block_counter[`TBL_BLK_TOP];
                nx.drv[j].mrev = r.drv[j].rev_cmd &
                    ~r.drv[j].block_counter[`TBL_BLK_TOP];
            end else begin
                nx.drv[j].mfwd = r.s2.man_fwd[j] & ~r.s2.man_rev[j];
                nx.drv[j].mrev = r.s2.man_rev[j] & ~r.s2.man_fwd[j];
            end
            // both brakes whenever neither direction is driven
            nx.drv[j].brake = ~(nx.drv[j].mfwd | nx.drv[j].mrev);
        end

        // shared write path for the selected unit
        if (r.wld_pend) begin
            nx.acc      = {mem_data_in[`TBL_PAIR_LO],
                           mem_data_in[`TBL_PAIR_HI]};
            nx.wbuf     = mem_data_in[`TBL_PAIR_HI];
            nx.fetch    = r.fetch + 10'h001;
            nx.wld_pend = 1'b0;
        end else if (r.drv[r.unit].pulse_route_flag && seq_write_flag_in
                     && lpe[r.unit]) begin
            nx.pair = r.wbuf;
            if (wpe[r.unit]) begin
                // word boundary: next word replaces the old one
                wld      = 1'b1;
                nx.acc   = {mem_data_in[`TBL_PAIR_LO],
                            mem_data_in[`TBL_PAIR_HI]};
                nx.wbuf  = mem_data_in[`TBL_PAIR_HI];
                nx.fetch = r.fetch + 10'h001;
            end else begin
                nx.wbuf = r.acc[`TBL_PAIR_HI];
                nx.acc  = {r.acc[`TBL_PAIR_LO], r.acc[`TBL_PAIR_HI]};
            end
        end

        // sticky events: set wins over a same-cycle clear
        for (int k = 0; k < 4; k++) begin
            nx.stat[k]     = nx.stat[k] | stp[k];
            nx.stat[k + 4] = nx.stat[k + 4] | (nx.drv[k].err &
                                               ~r.drv[k].err);
        end
        nx.irq = |(nx.stat & nx.mask);
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r        <= '0;
            r.hready <= 1'b1;
            r.mask   <= `TBL_IMASK_RST;
        end else begin
            r <= nx;
        end
    end

    // outputs straight from the state register
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            motor_fwd_out[k]  = r.drv[k].mfwd;
            motor_rev_out[k]  = r.drv[k].mrev;
            brake_out[k]      = r.drv[k].brake;
            erase_out[k]      = r.drv[k].erase;
            head_write_out[k] = r.drv[k].head_we;
        end
    end
    assign hrdata_out     = r.hrdata;
    assign hreadyout_out  = r.hready;
    assign hresp_out      = r.hresp;
    assign write_pair_out = r.pair;
    assign seq_out        = r.seq;
    assign mem_addr_out   = r.fetch;
    assign irq_out        = r.irq;

    // checks, repeated for every drive since each runs its own scenario, then one check of the shared word load
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    for (genvar g = 0; g < 4; g++) begin : g_drv_chk
        a_line_wrap: assert property (
            lpe[g] && r.drv[g].line_counter == `TBL_LINE_LAST
            |=> r.drv[g].line_counter == 5'h00)
            else $error("line counter did not wrap at 18");

        a_word_step: assert property (
            wpe[g] && r.drv[g].word_counter != `TBL_WORD_LAST
            |=> r.drv[g].word_counter ==
                $past(r.drv[g].word_counter) + 5'h01)
            else $error("word counter did not step on word pulse");

        a_block_stop: assert property (
            bpe[g] && r.drv[g].block_counter == `TBL_BLK_ZERO
            |=> r.drv[g].block_counter == 12'hfff &&
                r.drv[g].st == tbl_idle)
            else $error("zero count block pulse did not stop");

        a_pre_decr: assert property (
            r.drv[g].st == tbl_load && !lpe[g]
            |=> r.drv[g].st == tbl_decr ##1
            r.drv[g].block_counter == $past(r.drv[g].block_counter, 2)
                                      - `TBL_BLK_ONE)
            else $error("no decrement before motion");

        a_zero_gate: assert property (
            r.s2.auto_sel[g] && r.drv[g].block_counter[`TBL_BLK_TOP]
            |=> !motor_fwd_out[g] && !motor_rev_out[g])
            else $error("motion with block counter top bit set");

        a_manual_fwd: assert property (
            !r.s2.auto_sel[g] && r.s2.man_fwd[g] && !r.s2.man_rev[g]
            |=> motor_fwd_out[g] && !brake_out[g])
            else $error("manual forward not obeyed");

        a_route_fwd: assert property (
            lpe[g] && r.drv[g].pulse_route_flag |=> seq_out.line_pulse)
            else $error("routed line pulse not forwarded");

        a_route_off: assert property (
            lpe == (4'h1 << g) && !r.drv[g].pulse_route_flag
            |=> !seq_out.line_pulse)
            else $error("unrouted line pulse reached sequencer");

        a_erase_gate: assert property (
            head_write_out[g] |-> erase_out[g])
            else $error("head write without erase drive");

        // the motor output lags the stopped command by one register
        a_err_window: assert property (
            r.s2.auto_sel[g] && lpe[g] && r.drv[g].win != '0
            |=> r.drv[g].err ##1 !motor_fwd_out[g] [*2])
            else $error("line pulse in window not flagged");
    end

    a_word_load: assert property (
        wld |=> mem_addr_out == $past(mem_addr_out) + 10'h001)
        else $error("next word address not advanced");

endmodule

/* logic/tbl_params.svh */
// constants of the tape block locator
`ifndef TBL_PARAMS_SVH
`define TBL_PARAMS_SVH

// register byte offsets
`define TBL_REG_CMD    8'h00
`define TBL_REG_VADDR  8'h04
`define TBL_REG_STATUS 8'h08
`define TBL_REG_ISTAT  8'h0c
`define TBL_REG_IMASK  8'h10
`define TBL_REG_CLEAR  8'h14
`define TBL_REG_CNT0   8'h20
`define TBL_REG_CNT1   8'h24
`define TBL_REG_CNT2   8'h28
`define TBL_REG_CNT3   8'h2c

// register fields and the mask reset value
`define TBL_CMD_UNIT   1:0
`define TBL_CMD_OP     3:2
`define TBL_CMD_CNT    26:16
`define TBL_VADDR_F    9:0
`define TBL_DRV_F      3:0
`define TBL_IRQ_F      7:0
`define TBL_IMASK_RST  8'h00

// counter limits
`define TBL_LINE_LAST  5'd17
`define TBL_WORD_LAST  5'd31
`define TBL_BLK_TOP    11
`define TBL_BLK_ONE    12'h001
`define TBL_BLK_ZERO   12'h000

// write path
`define TBL_WORD_W     36
`define TBL_PAIR_HI    35:34
`define TBL_PAIR_LO    33:0

// error window timing
`define TBL_ERR_WIN_US 500
`define TBL_CLK_MHZ    250
`define TBL_WIN_W      17
`define TBL_WIN_ONE    17'h00001

`endif

/* logic/tbl_pkg.sv */
// types of the tape block locator
`include "tbl_params.svh"
package tbl_pkg;

    typedef enum logic [1:0] {
        tbl_op_adv   = 2'b00,
        tbl_op_back  = 2'b01,
        tbl_op_read  = 2'b10,
        tbl_op_write = 2'b11
    } tbl_op_t;

    typedef enum logic [1:0] {
        tbl_idle = 2'b00,
        tbl_load = 2'b01,
        tbl_decr = 2'b10,
        tbl_run  = 2'b11
    } tbl_dst_t;

    // pins from the tape units, one bit per drive
    typedef struct packed {
        logic [3:0] line_pulse;
        logic [3:0] auto_sel;
        logic [3:0] man_fwd;
        logic [3:0] man_rev;
    } tbl_pins_t;

    // pulses forwarded to the tape sequencer
    typedef struct packed {
        logic line_pulse;
        logic word_pulse;
        logic stop;
    } tbl_seq_t;

    typedef struct packed {
        tbl_dst_t               st;
        logic                   back;
        logic [4:0]             line_counter;
        logic [4:0]             word_counter;
        logic [11:0]            block_counter;
        logic                   pulse_route_flag;
        logic                   fwd_cmd;
        logic                   rev_cmd;
        logic                   err;
        logic [`TBL_WIN_W-1:0]  win;
        logic                   mfwd;
        logic                   mrev;
        logic                   brake;
        logic                   erase;
        logic                   head_we;
    } tbl_drv_t;

    typedef struct packed {
        tbl_drv_t [3:0]  drv;
        tbl_pins_t       s1;
        tbl_pins_t       s2;
        logic [3:0]      lp_d;
        logic [35:0]     acc;
        logic [1:0]      wbuf;
        logic [1:0]      pair;
        logic [9:0]      fetch;
        logic [9:0]      vaddr;
        logic            wld_pend;
        logic [1:0]      unit;
        tbl_op_t         op;
        logic [7:0]      stat;
        logic [7:0]      mask;
        logic            irq;
        logic [31:0]     hrdata;
        logic            hready;
        logic            hresp;
        logic            wpend;
        logic [7:0]      woff;
        tbl_seq_t        seq;
    } tbl_state_t;

endpackage

/* test/tbl_tape_model.sv */
// tape unit model: fixed-length blocks of line pulses while driven
`timescale 1ns/100ps
module tbl_tape_model #(
    parameter int LINES = 576,
    parameter int GAP   = 6
) (
    // drive from the locator
    input  wire logic fwd_in,
    input  wire logic rev_in,
    input  wire logic short_gap_in,
    // timing track
    output logic      line_pulse_out
);
    // track is still outside blocks; a started block is read whole (inertia)
    initial begin
        line_pulse_out = 1'b0;
        #1.3;
        forever begin
            if (fwd_in || rev_in) begin
                for (int i = 0; i < LINES; i++) begin
                    line_pulse_out = 1'b1;
                    #32;
                    line_pulse_out = 1'b0;
                    #32;
                end
                // a missing gap makes the next block run on, as a fault
                if (!short_gap_in) #(64 * GAP);
            end else begin
                #64;
            end
        end
    end
endmodule

/* test/tb.sv */
// self-checking bench of the tape block locator
`timescale 1ns/100ps
module tb;
    import tbl_pkg::*;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, wflag = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_out;
    logic        hreadyout_out, hresp_out, irq_out;
    logic [3:0]  auto_sel = 4'h0, man_fwd = 4'h0, sgap = 4'h0, lp;
    logic [3:0]  motor_fwd_out, motor_rev_out, brake_out;
    logic [3:0]  erase_out, head_write_out;
    logic [1:0]  write_pair_out;
    logic [9:0]  mem_addr_out;
    logic [35:0] mem [0:1023];
    tbl_seq_t    seq_out;
    tbl_pins_t   pins;
    logic [31:0] seed = 32'hf90ad111;
    logic [31:0] rq[$];
    logic [1:0]  pq[$];
    int          err_total = 0, samples_checked = 0;
    int          wp_n = 0, sp_n = 0, rv_n = 0;

    assign pins = {lp, auto_sel, man_fwd, 4'h0};

    tbl_locator #(.ERR_WIN_CYC(20)) tbl_locator_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .pins_in(pins), .motor_fwd_out(motor_fwd_out),
        .motor_rev_out(motor_rev_out), .brake_out(brake_out),
        .erase_out(erase_out), .head_write_out(head_write_out),
        .write_pair_out(write_pair_out), .seq_write_flag_in(wflag),
        .seq_out(seq_out), .mem_addr_out(mem_addr_out),
        .mem_data_in(mem[mem_addr_out]), .irq_out(irq_out));

    tbl_tape_model tape_inst [3:0] (.fwd_in(motor_fwd_out),
        .rev_in(motor_rev_out), .short_gap_in(sgap), .line_pulse_out(lp));

    // 250 mhz system clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] cmd(input logic [10:0] n,
                                        input logic [1:0] o,
                                        input logic [1:0] u);
        return {5'h0, n, 12'h0, o, u};
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // waits for hready at a rising edge, bounded
    task automatic hold();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (hreadyout_out !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            end_of_test();
        end
    endtask

    // one single ahb-lite transfer; c marks a read whose data is compared
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic c,
                       output logic [31:0] r);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hold();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        rd_ph <= c;
        hold();
        r = hrdata_out;
        rd_ph <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        rq.push_back(e);
        bus(a, 1'b0, 32'h0, 1'b1, r);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, 1'b0, r);
    endtask

    // polls the busy bit of drive u until it drops
    task automatic idle(input int u);
        logic [31:0] r;
        for (int n = 0; n < 12000; n++) begin
            bus(8'h08, 1'b0, 32'h0, 1'b0, r);
            if (r[u] === 1'b0) return;
        end
        err_total++;
        end_of_test();
    endtask

    // output watcher: takes the oldest note whenever a result appears
    always @(posedge clk_in) begin
        if (rd_ph && hreadyout_out === 1'b1) chk(hrdata_out, rq.pop_front());
        if (head_write_out[2] === 1'b1) chk({30'h0, write_pair_out},
            pq.size() ? {30'h0, pq.pop_front()} : 32'hbad);
        if (seq_out.word_pulse === 1'b1) wp_n++;
        if (seq_out.stop === 1'b1) sp_n++;
        if (motor_rev_out[1] === 1'b1) rv_n++;
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_in);
        err_total++;
        end_of_test();
    end

    initial begin
        logic [35:0] w;
        int v;
        for (int i = 0; i < 1024; i++) mem[i] = 36'({xs(), xs()});
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(8'h10, 32'h0);
        rd(8'h40, 32'h0);
        rd(8'h08, 32'h0);
        // zero blocks: wrap, stop, no motion
        wr(8'h00, cmd(11'h0, 2'b00, 2'b00));
        idle(0);
        rd(8'h20, 32'h00000fff);
        chk(motor_fwd_out, 32'h0);
        rd(8'h0c, 32'h1);
        wr(8'h10, 32'h1);
        rd(8'h10, 32'h1);
        chk(irq_out, 32'h1);
        wr(8'h0c, 32'h1);
        rd(8'h0c, 32'h0);
        chk(irq_out, 32'h0);
        // one block forward, then one back, pulses only counted
        auto_sel <= 4'hf;
        for (int o = 0; o < 2; o++) begin
            wr(8'h00, cmd(11'h1, 2'(o), 2'b01));
            idle(1);
            rd(8'h24, 32'h00000fff);
        end
        chk(32'(rv_n > 0), 32'h1);
        chk(32'(wp_n + sp_n), 32'h0);
        // one block written from random memory
        v = int'(xs() % 900);
        wr(8'h04, 32'(v));
        wflag <= 1'b1;
        for (int k = 0; k < 32; k++) begin
            w = mem[v + k];
            for (int p = 0; p < 18; p++) begin
                pq.push_back(w[35:34]);
                w = w << 2;
            end
        end
        wr(8'h00, cmd(11'h1, 2'b11, 2'b10));
        for (int n = 0; n < 2000 && pq.size() > 570; n++) @(posedge clk_in);
        if (pq.size() > 570) begin
            err_total++;
            end_of_test();
        end
        rd(8'h08, 32'h00000044);
        chk(erase_out, 32'h4);
        idle(2);
        chk(pq.size(), 32'h0);
        chk(wp_n, 32'd32);
        chk(sp_n, 32'h1);
        wflag <= 1'b0;
        // one block read on drive 0: pulses routed, nothing written
        wr(8'h00, cmd(11'h1, 2'b10, 2'b00));
        idle(0);
        chk(wp_n, 32'd64);
        chk(sp_n, 32'h2);
        chk(32'(hresp_out), 32'h0);
        // blocks run together: line pulse inside the window
        sgap <= 4'h8;
        wr(8'h00, cmd(11'h2, 2'b00, 2'b11));
        idle(3);
        rd(8'h08, 32'h00000800);
        chk(motor_fwd_out, 32'h0);
        wr(8'h14, 32'h8);
        rd(8'h08, 32'h0);
        sgap <= 4'h0;
        // manual selector overrides automatic control
        auto_sel <= 4'h7;
        man_fwd <= 4'h8;
        repeat (8) @(posedge clk_in);
        chk(motor_fwd_out, 32'h8);
        chk(brake_out, 32'h7);
        man_fwd <= 4'h0;
        repeat (8) @(posedge clk_in);
        chk(motor_fwd_out, 32'h0);
        chk(brake_out, 32'hf);
        end_of_test();
    end
endmodule
